// ### dte_pkg.sv
// Constants, register map and mode encoding for the dual timer block.
// Assumes an 8-bit special function register space on the core side.
package dte_pkg;

    // ------------------------------------------------------------
    // Register addresses
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL      = 8'h88;  // timer_run_and_ext_request_control
    localparam logic [7:0] ADDR_MODE      = 8'h89;  // timer_mode_select_register
    localparam logic [7:0] ADDR_TL_A      = 8'h8A;
    localparam logic [7:0] ADDR_TL_B      = 8'h8B;
    localparam logic [7:0] ADDR_TH_A      = 8'h8C;
    localparam logic [7:0] ADDR_TH_B      = 8'h8D;
    localparam logic [7:0] ADDR_PRESCALE  = 8'h8E;  // timer_prescale_control

    // ------------------------------------------------------------
    // Field positions (timer B field = timer A field + stride)
    // ------------------------------------------------------------
    localparam int CTRL_TYPE_LSB   = 0;
    localparam int CTRL_FLAG_LSB   = 1;
    localparam int CTRL_RUN_LSB    = 4;
    localparam int CTRL_OVF_LSB    = 5;
    localparam int CTRL_STRIDE     = 2;
    localparam int MODE_SEL_LSB    = 0;
    localparam int MODE_CT_BIT     = 2;
    localparam int MODE_GATE_BIT   = 3;
    localparam int MODE_STRIDE     = 4;
    localparam int PRESCALE_LSB    = 3;
    localparam logic [7:0] PRESCALE_MASK = 8'h18;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_BYTE  = 8'h00;
    localparam logic [1:0] RST_PAIR  = 2'h0;

    // ------------------------------------------------------------
    // Handler addresses that clear flags on vectoring
    // ------------------------------------------------------------
    localparam logic [15:0] VEC_EXT_A = 16'h0003;
    localparam logic [15:0] VEC_TMR_A = 16'h000B;
    localparam logic [15:0] VEC_EXT_B = 16'h0013;
    localparam logic [15:0] VEC_TMR_B = 16'h001B;

    // ------------------------------------------------------------
    // Counting constants
    // ------------------------------------------------------------
    localparam logic [4:0] LOW5_MAX   = 5'h1F;
    localparam logic [4:0] LOW5_ZERO  = 5'h00;
    localparam logic [4:0] LOW5_ONE   = 5'h01;
    localparam logic [7:0] BYTE_MAX   = 8'hFF;
    localparam logic [7:0] BYTE_ONE   = 8'h01;
    localparam logic [15:0] WORD_ONE  = 16'h0001;
    localparam logic [3:0] DIV12_LAST = 4'hB;
    localparam logic [3:0] DIV12_ZERO = 4'h0;
    localparam logic [3:0] DIV12_ONE  = 4'h1;

    typedef enum logic [1:0] {
        DTE_MODE_13BIT,
        DTE_MODE_16BIT,
        DTE_MODE_RELOAD8,
        DTE_MODE_SPLIT
    } dte_mode_t;

endpackage : dte_pkg

// ### dte_timer_core.sv
// Two timer/counters with external request flags, behind the core's
// special function register port. Assumes all inputs synchronous to clk_sys
// and that the core reports each vector taken with a one-cycle strobe.
//
// Summary of operation
// - Edge mode: B flag set on falling edge
// - Level mode: B flag follows low input
// - Edge mode: A flag set on falling edge
// - Level mode: A flag follows low input
// - Type bit set means edge, clear level
// - Mode 0: upper low-byte bits undefined
// - Mode 0 wrap past 1FFF sets flag
// - Timers advance only while run bit set
// - Select bit chooses clock or pin counting
// - Mode 1: full 16-bit counter wraps
// - Mode 2: low byte reloads from high
// - Mode 3: timer A splits, low uses A
// - Split high byte uses B run, flag
// - Timer B runs without overflow flag then
// - Timer B mode 3 holds its count
// - Gate bit adds high request input condition
// - Prescale bit picks clock or clock/12
// - Two mode bits select four modes
// - Overflow flags cleared on vectoring
`timescale 1ns/1ps

module dte_timer_core
    import dte_pkg::*;
(
    input  wire logic        clk_sys,              // Core clock, 20 MHz
    input  wire logic        rst,                  // Synchronous reset, active high
    input  wire logic [7:0]  sfr_addr,             // Register address
    input  wire logic        sfr_wr,               // Write strobe
    input  wire logic [7:0]  sfr_wdata,            // Write data
    input  wire logic        sfr_rd,               // Read strobe
    output logic      [7:0]  sfr_rdata,            // Read data, one cycle after strobe
    input  wire logic        vector_taken,         // Core vectors to a handler
    input  wire logic [15:0] vector_addr,          // Handler address with vector_taken
    input  wire logic        ext_request_a_input,  // External request pin A
    input  wire logic        ext_request_b_input,  // External request pin B
    input  wire logic        timer_a_event_pin,    // Event pin for timer A
    input  wire logic        timer_b_event_pin,    // Event pin for timer B
    output logic             ext_request_a_flag,   // Request A pending
    output logic             ext_request_b_flag,   // Request B pending
    output logic             timer_a_overflow_flag,// Timer A overflow pending
    output logic             timer_b_overflow_flag,// Timer B overflow pending
    output logic             timer_b_ovf_pulse     // Timer B rollover, baud source
);

    // ------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------
    logic [7:0]  mode_reg;
    logic [7:0]  prescale_reg;
    logic [1:0]  run_bit;
    logic [1:0]  type_bit;
    logic [1:0]  ext_flag;
    logic [1:0]  ovf_flag;
    logic [7:0]  tl_q [2];
    logic [7:0]  th_q [2];
    logic [1:0]  ovf_evt;
    logic        split_hi_ovf;

    // ------------------------------------------------------------
    // Pin sampling and clock/12 divider
    // ------------------------------------------------------------
    logic [1:0]  ext_in;
    logic [1:0]  ext_prev;
    logic [1:0]  ev_in;
    logic [1:0]  ev_prev;
    logic [1:0]  ext_fall;
    logic [1:0]  ev_fall;
    logic [3:0]  div_cnt;
    logic        div_tick;

    assign ext_in   = {ext_request_b_input, ext_request_a_input};
    assign ev_in    = {timer_b_event_pin, timer_a_event_pin};
    assign ext_fall = ext_prev & ~ext_in;
    assign ev_fall  = ev_prev & ~ev_in;
    assign div_tick = (div_cnt == DIV12_LAST);

    // Previous samples reset low, so a pin held low out of reset shows no false fall
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ext_prev <= RST_PAIR;
            ev_prev  <= RST_PAIR;
        end else begin
            ext_prev <= ext_in;
            ev_prev  <= ev_in;
        end
    end

    // Free-running, so the first clk/12 tick after enabling may come early
    always_ff @(posedge clk_sys) begin
        if (rst || div_tick) begin
            div_cnt <= DIV12_ZERO;
        end else begin
            div_cnt <= div_cnt + DIV12_ONE;
        end
    end

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    logic wr_ctrl;
    assign wr_ctrl = sfr_wr && (sfr_addr == ADDR_CTRL);

    // Prescale keeps only the two timer selects; the rest reads back as zero
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            mode_reg     <= RST_BYTE;
            prescale_reg <= RST_BYTE;
        end else begin
            if (sfr_wr && (sfr_addr == ADDR_MODE)) begin
                mode_reg <= sfr_wdata;
            end
            if (sfr_wr && (sfr_addr == ADDR_PRESCALE)) begin
                prescale_reg <= sfr_wdata & PRESCALE_MASK;
            end
        end
    end

    // ------------------------------------------------------------
    // Per-timer counting
    // ------------------------------------------------------------
    // One slice per timer: index 0 is timer A, index 1 is timer B
    genvar i;
    generate
        for (i = 0; i < 2; i++) begin : g_tmr
            logic [7:0]  tl;
            logic [7:0]  th;
            logic [7:0]  next_tl;
            logic [7:0]  next_th;
            logic        next_ovf;
            logic        next_hi_ovf;
            logic        clk_tick;
            logic        adv;
            logic        hi_adv;
            logic        gate_ok;
            logic        count_src;
            dte_mode_t   mode;
            logic [15:0] word_inc;
            logic [7:0]  tl_addr;
            logic [7:0]  th_addr;

            assign tl_addr  = (i == 0) ? ADDR_TL_A : ADDR_TL_B;
            assign th_addr  = (i == 0) ? ADDR_TH_A : ADDR_TH_B;
            assign mode     = dte_mode_t'(mode_reg[i*MODE_STRIDE+MODE_SEL_LSB +: 2]);
            assign clk_tick = prescale_reg[PRESCALE_LSB+i] | div_tick;
            assign gate_ok  = ~mode_reg[i*MODE_STRIDE+MODE_GATE_BIT] | ext_in[i];
            assign count_src = mode_reg[i*MODE_STRIDE+MODE_CT_BIT] ? ev_fall[i] : clk_tick;
            assign adv      = run_bit[i] & gate_ok & count_src;
            // Split high byte counts timer A's clock or clock/12 tick only, under timer B run
            // Ignores timer A's gate and select, so it cannot count pin events
            assign hi_adv   = (i == 0) && (mode == DTE_MODE_SPLIT)
                            && run_bit[1] && clk_tick;
            assign word_inc = {th, tl} + WORD_ONE;

            always_comb begin
                next_tl     = tl;
                next_th     = th;
                next_ovf    = 1'b0;
                next_hi_ovf = 1'b0;
                if (adv) begin
                    case (mode)
                        DTE_MODE_13BIT: begin
                            // Bits 7:5 of the low byte are left alone: undefined to software
                            if (tl[4:0] == LOW5_MAX) begin
                                next_tl  = {tl[7:5], LOW5_ZERO};
                                next_th  = th + BYTE_ONE;
                                next_ovf = (th == BYTE_MAX);
                            end else begin
                                next_tl = {tl[7:5], tl[4:0] + LOW5_ONE};
                            end
                        end
                        DTE_MODE_16BIT: begin
                            next_tl  = word_inc[7:0];
                            next_th  = word_inc[15:8];
                            next_ovf = (tl == BYTE_MAX) && (th == BYTE_MAX);
                        end
                        DTE_MODE_RELOAD8: begin
                            if (tl == BYTE_MAX) begin
                                next_tl  = th;
                                next_ovf = 1'b1;
                            end else begin
                                next_tl = tl + BYTE_ONE;
                            end
                        end
                        DTE_MODE_SPLIT: begin
                            if (i == 0) begin
                                next_tl  = tl + BYTE_ONE;
                                next_ovf = (tl == BYTE_MAX);
                            end
                            // Timer B in this mode holds its count
                        end
                        default: begin
                            next_tl = tl;
                        end
                    endcase
                end
                if (hi_adv) begin
                    next_th     = th + BYTE_ONE;
                    next_hi_ovf = (th == BYTE_MAX);
                end
            end

            // Software write wins over a count in the same cycle
            always_ff @(posedge clk_sys) begin
                if (rst) begin
                    tl <= RST_BYTE;
                    th <= RST_BYTE;
                end else begin
                    tl <= (sfr_wr && (sfr_addr == tl_addr)) ? sfr_wdata : next_tl;
                    th <= (sfr_wr && (sfr_addr == th_addr)) ? sfr_wdata : next_th;
                end
            end

            assign tl_q[i]    = tl;
            assign th_q[i]    = th;
            assign ovf_evt[i] = next_ovf;
            if (i == 0) begin : g_split
                assign split_hi_ovf = next_hi_ovf;
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Run, type and flag bits
    // ------------------------------------------------------------
    logic        a_split;
    logic [1:0]  ovf_set;
    logic [1:0]  ovf_vec;
    logic [1:0]  ext_vec;

    assign a_split    = (dte_mode_t'(mode_reg[MODE_SEL_LSB +: 2]) == DTE_MODE_SPLIT);
    assign ovf_set[0] = ovf_evt[0];
    // Timer B still runs under its own run bit, as a baud source
    // Split high byte takes over timer B's flag
    assign ovf_set[1] = a_split ? split_hi_ovf : ovf_evt[1];
    // Vector clears act only in the strobe's cycle, matched on its address
    assign ovf_vec[0] = vector_taken && (vector_addr == VEC_TMR_A);
    assign ovf_vec[1] = vector_taken && (vector_addr == VEC_TMR_B);
    assign ext_vec[0] = vector_taken && (vector_addr == VEC_EXT_A);
    assign ext_vec[1] = vector_taken && (vector_addr == VEC_EXT_B);

    generate
        for (i = 0; i < 2; i++) begin : g_flag
            // Bit positions of this timer's slice of the control register
            localparam int TYPE_POS = CTRL_TYPE_LSB + i*CTRL_STRIDE;
            localparam int FLAG_POS = CTRL_FLAG_LSB + i*CTRL_STRIDE;
            localparam int RUN_POS  = CTRL_RUN_LSB + i*CTRL_STRIDE;
            localparam int OVF_POS  = CTRL_OVF_LSB + i*CTRL_STRIDE;

            always_ff @(posedge clk_sys) begin
                if (rst) begin
                    run_bit[i]  <= 1'b0;
                    type_bit[i] <= 1'b0;
                end else if (wr_ctrl) begin
                    run_bit[i]  <= sfr_wdata[RUN_POS];
                    type_bit[i] <= sfr_wdata[TYPE_POS];
                end
            end

            // Hardware set beats software or vector clear
            always_ff @(posedge clk_sys) begin
                if (rst) begin
                    ovf_flag[i] <= 1'b0;
                end else if (ovf_set[i]) begin
                    ovf_flag[i] <= 1'b1;
                end else if (wr_ctrl) begin
                    ovf_flag[i] <= sfr_wdata[OVF_POS];
                end else if (ovf_vec[i]) begin
                    ovf_flag[i] <= 1'b0;
                end
            end

            // Level mode tracks the pin; edge mode latches until cleared
            always_ff @(posedge clk_sys) begin
                if (rst) begin
                    ext_flag[i] <= 1'b0;
                end else if (!type_bit[i]) begin
                    // Level mode: flag is the inverted pin, writes ignored
                    ext_flag[i] <= ~ext_in[i];
                end else if (ext_fall[i]) begin
                    ext_flag[i] <= 1'b1;
                end else if (wr_ctrl) begin
                    ext_flag[i] <= sfr_wdata[FLAG_POS];
                end else if (ext_vec[i]) begin
                    ext_flag[i] <= 1'b0;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Timer B rollover pulse for a baud generator
    // ------------------------------------------------------------
    // Pulses even while split mode owns the flag, so baud use keeps working
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            timer_b_ovf_pulse <= 1'b0;
        end else begin
            timer_b_ovf_pulse <= ovf_evt[1];
        end
    end

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    // Read data is registered: one cycle late, held until the next read
    logic [7:0] ctrl_view;
    assign ctrl_view = {ovf_flag[1], run_bit[1],
                        ovf_flag[0], run_bit[0],
                        ext_flag[1], type_bit[1],
                        ext_flag[0], type_bit[0]};

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sfr_rdata <= RST_BYTE;
        end else if (sfr_rd) begin
            case (sfr_addr)
                ADDR_CTRL:     sfr_rdata <= ctrl_view;
                ADDR_MODE:     sfr_rdata <= mode_reg;
                ADDR_TL_A:     sfr_rdata <= tl_q[0];
                ADDR_TL_B:     sfr_rdata <= tl_q[1];
                ADDR_TH_A:     sfr_rdata <= th_q[0];
                ADDR_TH_B:     sfr_rdata <= th_q[1];
                ADDR_PRESCALE: sfr_rdata <= prescale_reg;
                default:       sfr_rdata <= RST_BYTE;
            endcase
        end
    end

    assign ext_request_a_flag    = ext_flag[0];
    assign ext_request_b_flag    = ext_flag[1];
    assign timer_a_overflow_flag = ovf_flag[0];
    assign timer_b_overflow_flag = ovf_flag[1];

endmodule : dte_timer_core

// ### dte_timer_core_monitor.sv
// Port-level assertions for the dual timer block.
// Assumes it is bound to dte_timer_core and sees only its ports.
`timescale 1ns/1ps
module dte_timer_core_monitor
    import dte_pkg::*;
(
    input wire logic        clk_sys,               // Clock
    input wire logic        rst,                   // Reset
    input wire logic [7:0]  sfr_addr,              // Address
    input wire logic        sfr_wr,                // Write
    input wire logic [7:0]  sfr_wdata,             // Write data
    input wire logic        sfr_rd,                // Read
    input wire logic [7:0]  sfr_rdata,             // Read data
    input wire logic        vector_taken,          // Vector strobe
    input wire logic [15:0] vector_addr,           // Vector target
    input wire logic        ext_request_a_input,   // Pin A
    input wire logic        ext_request_b_input,   // Pin B
    input wire logic        timer_a_event_pin,     // Event A
    input wire logic        timer_b_event_pin,     // Event B
    input wire logic        ext_request_a_flag,    // Flag A
    input wire logic        ext_request_b_flag,    // Flag B
    input wire logic        timer_a_overflow_flag, // Overflow A
    input wire logic        timer_b_overflow_flag, // Overflow B
    input wire logic        timer_b_ovf_pulse      // Rollover B
);
    // ----------------------------------------
    // Shadow of software-owned control bits
    // ----------------------------------------
    logic [7:0] ctrl_q;  // Flag bits go stale, only types and runs used
    logic [7:0] mode_q;
    logic       ctrl_wr;

    assign ctrl_wr = sfr_wr && (sfr_addr == ADDR_CTRL);

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ctrl_q <= 8'h00;
            mode_q <= 8'h00;
        end else if (ctrl_wr) begin
            ctrl_q <= sfr_wdata;
        end else if (sfr_wr && sfr_addr == ADDR_MODE) begin
            mode_q <= sfr_wdata;
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    AST_EXTA_LEVEL: assert property (!ctrl_q[0] && !(ctrl_wr && sfr_wdata[0])
        |=> ext_request_a_flag == !$past(ext_request_a_input)) else $error("Level flag A off pin");
    AST_EXTB_LEVEL: assert property (!ctrl_q[2] && !(ctrl_wr && sfr_wdata[2])
        |=> ext_request_b_flag == !$past(ext_request_b_input)) else $error("Level flag B off pin");
    AST_EXTA_EDGE: assert property (ctrl_q[0] && !(ctrl_wr && !sfr_wdata[0]) && $fell(ext_request_a_input)
        |=> ext_request_a_flag) else $error("Fall on A not flagged");
    AST_EXTB_EDGE: assert property (ctrl_q[2] && !(ctrl_wr && !sfr_wdata[2]) && $fell(ext_request_b_input)
        |=> ext_request_b_flag) else $error("Fall on B not flagged");
    AST_EXTA_VEC: assert property (ctrl_q[0] && !ctrl_wr && !$fell(ext_request_a_input) && vector_taken
        && vector_addr == VEC_EXT_A |=> !ext_request_a_flag) else $error("Vector left flag A");
    AST_EXTB_VEC: assert property (ctrl_q[2] && !ctrl_wr && !$fell(ext_request_b_input) && vector_taken
        && vector_addr == VEC_EXT_B |=> !ext_request_b_flag) else $error("Vector left flag B");
    AST_OVFA_STOP: assert property (!ctrl_q[4] && !ctrl_wr |=> !$rose(timer_a_overflow_flag))
        else $error("Overflow A while stopped");
    AST_OVFB_STOP: assert property (!ctrl_q[6] && !ctrl_wr |=> !$rose(timer_b_overflow_flag))
        else $error("Overflow B while stopped");
    AST_B_HOLD: assert property (mode_q[5:4] == 2'h3 |=> !timer_b_ovf_pulse) else $error("B rolled in mode 3");

    COV_OVF_A: cover property ($rose(timer_a_overflow_flag));
    COV_OVF_B: cover property ($rose(timer_b_overflow_flag));
    COV_EDGE_A: cover property (ctrl_q[0] && $rose(ext_request_a_flag));
endmodule : dte_timer_core_monitor

bind dte_timer_core dte_timer_core_monitor u_mon (
    .clk_sys(clk_sys), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd),
    .sfr_rdata(sfr_rdata), .vector_taken(vector_taken), .vector_addr(vector_addr),
    .ext_request_a_input(ext_request_a_input), .ext_request_b_input(ext_request_b_input),
    .timer_a_event_pin(timer_a_event_pin), .timer_b_event_pin(timer_b_event_pin),
    .ext_request_a_flag(ext_request_a_flag), .ext_request_b_flag(ext_request_b_flag),
    .timer_a_overflow_flag(timer_a_overflow_flag), .timer_b_overflow_flag(timer_b_overflow_flag),
    .timer_b_ovf_pulse(timer_b_ovf_pulse)
);

// ### test_dual_timer_ext_irq_flags.sv
// Self-checking bench for the dual timer block through its register port.
// Assumes a 20 MHz core clock and one-cycle read latency.
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin failures++; \
    $display("[FAIL] %0t got %h exp %h", $time, (g), (e)); end end

module test_dual_timer_ext_irq_flags
    import dte_pkg::*;
;
    logic        clk_sys = 1'b0, rst = 1'b1, sfr_wr = 1'b0, sfr_rd = 1'b0, vector_taken = 1'b0;
    logic [7:0]  sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata;
    logic [15:0] vector_addr = 16'h0000;
    logic        ext_a = 1'b1, ext_b = 1'b1, ev_a = 1'b1, ev_b = 1'b1;
    logic        flag_a, flag_b, ovf_a, ovf_b, pulse_b;
    int          failures = 0, n_compared = 0;

    always #25 clk_sys = ~clk_sys;

    dte_timer_core dut (
        .clk_sys(clk_sys), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata),
        .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .vector_taken(vector_taken), .vector_addr(vector_addr),
        .ext_request_a_input(ext_a), .ext_request_b_input(ext_b), .timer_a_event_pin(ev_a),
        .timer_b_event_pin(ev_b), .ext_request_a_flag(flag_a), .ext_request_b_flag(flag_b),
        .timer_a_overflow_flag(ovf_a), .timer_b_overflow_flag(ovf_b), .timer_b_ovf_pulse(pulse_b)
    );

    // ----------------------------------------
    // Bus and sequence tasks
    // ----------------------------------------
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys) {sfr_wr, sfr_addr, sfr_wdata} <= {1'b1, a, d};
        @(posedge clk_sys) sfr_wr <= 1'b0;
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
        @(posedge clk_sys) {sfr_rd, sfr_addr} <= {1'b1, a};
        @(posedge clk_sys) sfr_rd <= 1'b0;
        #1;
        `CHK(sfr_rdata & m, e)
    endtask : rd_chk

    task automatic vec(input logic [15:0] v);
        @(posedge clk_sys) {vector_taken, vector_addr} <= {1'b1, v};
        @(posedge clk_sys) vector_taken <= 1'b0;
    endtask : vec

    task automatic step(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : step

    // A window runs the timer for n + 2 edges: the stop write adds two edges before the run bit clears
    task automatic window(input logic [7:0] ctl, input int n);
        wr(ADDR_CTRL, ctl);
        step(n);
        wr(ADDR_CTRL, 8'h00);
    endtask : window

    // Gate held shut by pin A low, then opened for exactly one edge
    task automatic one_count(input logic [7:0] mode, tl, th, etl, eth, m, input logic eovf);
        wr(ADDR_MODE, mode);
        wr(ADDR_TL_A, tl);
        wr(ADDR_TH_A, th);
        vec(VEC_TMR_A);
        rd_chk(ADDR_TL_A, m, tl & m);
        @(posedge clk_sys) ext_a <= 1'b1;
        @(posedge clk_sys) ext_a <= 1'b0;
        step(1);
        `CHK(ovf_a, eovf)
        rd_chk(ADDR_TL_A, m, etl);
        rd_chk(ADDR_TH_A, 8'hFF, eth);
    endtask : one_count

    task automatic print_verdict;
        $display("Compared %0d, mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : print_verdict

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (20) @(posedge clk_sys);
        rst <= 1'b0;
        for (int a = 8'h88; a <= 8'h8E; a++) rd_chk(8'(a), 8'hFF, 8'h00);
        wr(8'h80, 8'h5A);
        rd_chk(8'h80, 8'hFF, 8'h00);
        wr(ADDR_PRESCALE, 8'hFF);
        rd_chk(ADDR_PRESCALE, 8'hFF, 8'h18);
        wr(ADDR_MODE, 8'hA5);
        rd_chk(ADDR_MODE, 8'hFF, 8'hA5);
        $display("Test map done");
        @(posedge clk_sys) {ext_a, ext_b} <= 2'b00;
        step(2);
        `CHK({flag_a, flag_b}, 2'b11)
        wr(ADDR_CTRL, 8'h00);
        step(1);
        `CHK({flag_a, flag_b}, 2'b11)
        @(posedge clk_sys) {ext_a, ext_b} <= 2'b11;
        step(2);
        `CHK({flag_a, flag_b}, 2'b00)
        $display("Test level done");
        wr(ADDR_CTRL, 8'h05);
        @(posedge clk_sys) {ext_a, ext_b} <= 2'b00;
        step(2);
        rd_chk(ADDR_CTRL, 8'hFF, 8'h0F);
        @(posedge clk_sys) {ext_a, ext_b} <= 2'b11;
        step(2);
        `CHK({flag_a, flag_b}, 2'b11)
        wr(ADDR_CTRL, 8'h05);
        step(1);
        `CHK({flag_a, flag_b}, 2'b00)
        @(posedge clk_sys) {ext_a, ext_b} <= 2'b00;
        step(2);
        vec(VEC_EXT_A);
        step(1);
        `CHK({flag_a, flag_b}, 2'b01)
        vec(VEC_EXT_B);
        step(1);
        `CHK({flag_a, flag_b}, 2'b00)
        wr(ADDR_CTRL, 8'h00);
        $display("Test edge done");
        wr(ADDR_PRESCALE, 8'h08);
        wr(ADDR_MODE, 8'h09);
        wr(ADDR_CTRL, 8'h10);
        one_count(8'h09, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'hFF, 1'b1);
        one_count(8'h08, 8'h1F, 8'h00, 8'h00, 8'h01, 8'h1F, 1'b0);
        one_count(8'h08, 8'h1F, 8'hFF, 8'h00, 8'h00, 8'h1F, 1'b1);
        one_count(8'h0A, 8'hFF, 8'hC8, 8'hC8, 8'hC8, 8'hFF, 1'b1);
        $display("Test modes done");
        wr(ADDR_CTRL, 8'h00);
        wr(ADDR_MODE, 8'h01);
        wr(ADDR_TL_A, 8'h00);
        window(8'h10, 100);
        step(4);
        rd_chk(ADDR_TL_A, 8'hFF, 8'h66);
        wr(ADDR_PRESCALE, 8'h00);
        wr(ADDR_TL_A, 8'h00);
        window(8'h10, 118);
        rd_chk(ADDR_TL_A, 8'hFF, 8'h0A);
        wr(ADDR_MODE, 8'h05);
        wr(ADDR_TL_A, 8'h00);
        wr(ADDR_CTRL, 8'h10);
        repeat (5) begin
            @(posedge clk_sys) ev_a <= 1'b0;
            @(posedge clk_sys) ev_a <= 1'b1;
        end
        wr(ADDR_CTRL, 8'h00);
        rd_chk(ADDR_TL_A, 8'hFF, 8'h05);
        $display("Test rate done");
        wr(ADDR_PRESCALE, 8'h18);
        wr(ADDR_MODE, 8'h13);
        wr(ADDR_TL_A, 8'h00);
        wr(ADDR_TH_A, 8'h10);
        wr(ADDR_TL_B, 8'hFF);
        wr(ADDR_TH_B, 8'hFF);
        wr(ADDR_CTRL, 8'h40);
        step(1);
        `CHK(pulse_b, 1'b1)
        step(1);
        `CHK(ovf_b, 1'b0)
        wr(ADDR_CTRL, 8'h00);
        rd_chk(ADDR_TH_A, 8'hFF, 8'h14);
        rd_chk(ADDR_TL_A, 8'hFF, 8'h00);
        rd_chk(ADDR_TL_B, 8'hFF, 8'h03);
        wr(ADDR_TH_A, 8'hFE);
        wr(ADDR_CTRL, 8'h40);
        step(2);
        `CHK(ovf_b, 1'b1)
        `CHK(pulse_b, 1'b0)
        wr(ADDR_MODE, 8'h31);
        wr(ADDR_TL_B, 8'h10);
        window(8'h40, 4);
        rd_chk(ADDR_TL_B, 8'hFF, 8'h10);
        $display("Test split done");
        print_verdict;
    end
endmodule : test_dual_timer_ext_irq_flags
